// *** verilog/move_timing_cfg.svh ***
`ifndef MOVE_TIMING_CFG_SVH
`define MOVE_TIMING_CFG_SVH

// extended data page reset value
`define XPAGE_RESET 8'h01
// width of the wait-state count
`define WAIT_W 4
// width of a state count
`define STATE_W 8
// penalty for an i/o port and for a peripheral register operand
`define PORT_EXTRA 8'h01
`define PERIPH_EXTRA 8'h02

`endif

// *** verilog/move_timing_pkg.sv ***
package move_timing_pkg;

    // instruction form selected by the decoder
    typedef enum logic [5:0] {
        MV_A_BNK = 6'h00,
        MV_A_D8 = 6'h01,
        MV_A_IND = 6'h02,
        MV_A_IMM = 6'h03,
        MV_BNK_A = 6'h04,
        MV_BNK_D8 = 6'h05,
        MV_BNK_IMM = 6'h06,
        MV_D8_A = 6'h07,
        MV_D8_BNK = 6'h08,
        MV_D8_D8 = 6'h09,
        MV_D8_IND = 6'h0A,
        MV_D8_IMM = 6'h0B,
        MV_IND_A = 6'h0C,
        MV_IND_D8 = 6'h0D,
        MV_IND_IMM = 6'h0E,
        MV_PTR16_IMM16 = 6'h0F,
        MV_BYT_BYT = 6'h10,
        MV_WR_WR = 6'h11,
        MV_DR_DR = 6'h12,
        MV_BYT_IMM = 6'h13,
        MV_WR_IMM16 = 6'h14,
        MV_DR_IMM0 = 6'h15,
        MV_DR_IMM1 = 6'h16,
        MV_BYT_D8 = 6'h17,
        MV_WR_D8 = 6'h18,
        MV_DR_D8 = 6'h19,
        MV_BYT_D16 = 6'h1A,
        MV_WR_D16 = 6'h1B,
        MV_DR_D16 = 6'h1C,
        MV_BYT_IWR = 6'h1D,
        MV_BYT_IDR = 6'h1E,
        MV_WR_IWR = 6'h1F,
        MV_WR_IDR = 6'h20,
        MV_D8_BYT = 6'h21,
        MV_D8_WR = 6'h22,
        MV_D8_DR = 6'h23,
        MV_D16_BYT = 6'h24,
        MV_D16_WR = 6'h25,
        MV_D16_DR = 6'h26,
        MV_IWR_BYT = 6'h27,
        MV_IDR_BYT = 6'h28,
        MV_IWR_WR = 6'h29,
        MV_IDR_WR = 6'h2A,
        MV_BYT_IWRD = 6'h2B,
        MV_WR_IWRD = 6'h2C,
        MV_BYT_IDRD = 6'h2D,
        MV_WR_IDRD = 6'h2E,
        MV_IWRD_BYT = 6'h2F,
        MV_IWRD_WR = 6'h30,
        MV_IDRD_BYT = 6'h31,
        MV_IDRD_WR = 6'h32,
        MV_X_A_IND = 6'h33,
        MV_X_A_PTR16 = 6'h34,
        MV_X_IND_A = 6'h35,
        MV_X_PTR16_A = 6'h36
    } move_form_t;

    // kind of location a direct operand resolves to
    typedef enum logic [1:0] {
        LOC_RAM = 2'h0,
        LOC_PORT = 2'h1,
        LOC_PERIPH = 2'h2
    } dir_loc_t;

    // external penalty class
    typedef enum logic [2:0] {
        XP_NONE = 3'h0,
        XP_N1 = 3'h1,
        XP_N2 = 3'h2,
        XP_WORD = 3'h3,
        XP_DWORD = 3'h4
    } ext_pen_t;

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_DONE = 3'b100
    } seq_state_t;

endpackage : move_timing_pkg

// *** verilog/move_cost_table.sv ***
`timescale 1ns/1ns
`include "move_timing_cfg.svh"

// base byte and state counts per form, both opcode-map modes
module move_cost_table
    import move_timing_pkg::*;
(
    input wire move_form_t form_i,
    input wire logic source_mode_i,
    output logic [2:0] bytes_o,
    output logic [`STATE_W-1:0] states_o,
    output logic [1:0] dir_ops_o,
    output ext_pen_t ext_pen_o
);
    logic [2:0] bb;
    logic [2:0] sb;
    logic [3:0] bs;
    logic [3:0] ss;

    // {binary bytes, binary states, source bytes, source states}
    always_comb begin
        dir_ops_o = 2'h0;
        ext_pen_o = XP_NONE;
        case (form_i)
            MV_A_BNK: {bb, bs, sb, ss} = {3'd1, 4'd1, 3'd2, 4'd2};
            MV_A_D8: begin
                {bb, bs, sb, ss} = {3'd2, 4'd1, 3'd2, 4'd1};
                dir_ops_o = 2'h1;
            end
            MV_A_IND: {bb, bs, sb, ss} = {3'd1, 4'd2, 3'd2, 4'd3};
            MV_A_IMM: {bb, bs, sb, ss} = {3'd2, 4'd1, 3'd2, 4'd1};
            MV_BNK_A: {bb, bs, sb, ss} = {3'd1, 4'd1, 3'd2, 4'd2};
            MV_BNK_D8: begin
                {bb, bs, sb, ss} = {3'd2, 4'd1, 3'd3, 4'd2};
                dir_ops_o = 2'h1;
            end
            MV_BNK_IMM: {bb, bs, sb, ss} = {3'd2, 4'd1, 3'd3, 4'd2};
            MV_D8_A: begin
                {bb, bs, sb, ss} = {3'd2, 4'd2, 3'd2, 4'd2};
                dir_ops_o = 2'h1;
            end
            MV_D8_BNK: begin
                {bb, bs, sb, ss} = {3'd2, 4'd2, 3'd3, 4'd3};
                dir_ops_o = 2'h1;
            end
            MV_D8_D8: begin
                {bb, bs, sb, ss} = {3'd3, 4'd3, 3'd3, 4'd3};
                dir_ops_o = 2'h2;
            end
            MV_D8_IND: begin
                {bb, bs, sb, ss} = {3'd2, 4'd3, 3'd3, 4'd4};
                dir_ops_o = 2'h1;
            end
            MV_D8_IMM: begin
                {bb, bs, sb, ss} = {3'd3, 4'd3, 3'd3, 4'd3};
                dir_ops_o = 2'h1;
            end
            MV_IND_A: {bb, bs, sb, ss} = {3'd1, 4'd3, 3'd2, 4'd4};
            MV_IND_D8: begin
                {bb, bs, sb, ss} = {3'd2, 4'd3, 3'd3, 4'd4};
                dir_ops_o = 2'h1;
            end
            MV_IND_IMM: {bb, bs, sb, ss} = {3'd2, 4'd3, 3'd3, 4'd4};
            MV_PTR16_IMM16: {bb, bs, sb, ss} = {3'd3, 4'd2, 3'd3, 4'd2};
            MV_BYT_BYT: {bb, bs, sb, ss} = {3'd3, 4'd2, 3'd2, 4'd1};
            MV_WR_WR: {bb, bs, sb, ss} = {3'd3, 4'd2, 3'd2, 4'd1};
            MV_DR_DR: {bb, bs, sb, ss} = {3'd3, 4'd3, 3'd2, 4'd2};
            MV_BYT_IMM: {bb, bs, sb, ss} = {3'd4, 4'd3, 3'd3, 4'd2};
            MV_WR_IMM16: {bb, bs, sb, ss} = {3'd5, 4'd3, 3'd4, 4'd2};
            MV_DR_IMM0, MV_DR_IMM1: {bb, bs, sb, ss} = {3'd5, 4'd5, 3'd4, 4'd4};
            MV_BYT_D8: begin
                {bb, bs, sb, ss} = {3'd4, 4'd3, 3'd3, 4'd2};
                dir_ops_o = 2'h1;
            end
            MV_WR_D8: {bb, bs, sb, ss} = {3'd4, 4'd4, 3'd3, 4'd3};
            MV_DR_D8: {bb, bs, sb, ss} = {3'd4, 4'd6, 3'd3, 4'd5};
            MV_BYT_D16: begin
                {bb, bs, sb, ss} = {3'd5, 4'd3, 3'd4, 4'd2};
                ext_pen_o = XP_N2;
            end
            MV_WR_D16: begin
                {bb, bs, sb, ss} = {3'd5, 4'd4, 3'd4, 4'd3};
                ext_pen_o = XP_WORD;
            end
            MV_DR_D16: begin
                {bb, bs, sb, ss} = {3'd5, 4'd6, 3'd4, 4'd5};
                ext_pen_o = XP_DWORD;
            end
            MV_BYT_IWR: begin
                {bb, bs, sb, ss} = {3'd4, 4'd3, 3'd3, 4'd2};
                ext_pen_o = XP_N2;
            end
            MV_BYT_IDR: begin
                {bb, bs, sb, ss} = {3'd4, 4'd4, 3'd3, 4'd3};
                ext_pen_o = XP_N2;
            end
            MV_WR_IWR: begin
                {bb, bs, sb, ss} = {3'd4, 4'd4, 3'd3, 4'd3};
                ext_pen_o = XP_WORD;
            end
            MV_WR_IDR: begin
                {bb, bs, sb, ss} = {3'd4, 4'd5, 3'd3, 4'd4};
                ext_pen_o = XP_WORD;
            end
            MV_D8_BYT: begin
                {bb, bs, sb, ss} = {3'd4, 4'd4, 3'd3, 4'd3};
                dir_ops_o = 2'h1;
            end
            MV_D8_WR: {bb, bs, sb, ss} = {3'd4, 4'd5, 3'd3, 4'd4};
            MV_D8_DR: {bb, bs, sb, ss} = {3'd4, 4'd7, 3'd3, 4'd6};
            MV_D16_BYT: begin
                {bb, bs, sb, ss} = {3'd5, 4'd4, 3'd4, 4'd3};
                ext_pen_o = XP_N2;
            end
            MV_D16_WR: begin
                {bb, bs, sb, ss} = {3'd5, 4'd5, 3'd4, 4'd4};
                ext_pen_o = XP_WORD;
            end
            MV_D16_DR: begin
                {bb, bs, sb, ss} = {3'd5, 4'd7, 3'd4, 4'd6};
                ext_pen_o = XP_DWORD;
            end
            MV_IWR_BYT: begin
                {bb, bs, sb, ss} = {3'd4, 4'd4, 3'd3, 4'd3};
                ext_pen_o = XP_N2;
            end
            MV_IDR_BYT: begin
                {bb, bs, sb, ss} = {3'd4, 4'd5, 3'd3, 4'd4};
                ext_pen_o = XP_N2;
            end
            MV_IWR_WR: begin
                {bb, bs, sb, ss} = {3'd4, 4'd5, 3'd3, 4'd4};
                ext_pen_o = XP_WORD;
            end
            MV_IDR_WR: begin
                {bb, bs, sb, ss} = {3'd4, 4'd6, 3'd3, 4'd5};
                ext_pen_o = XP_WORD;
            end
            MV_BYT_IWRD, MV_IWRD_BYT: begin
                {bb, bs, sb, ss} = {3'd5, 4'd6, 3'd4, 4'd5};
                ext_pen_o = XP_N2;
            end
            MV_WR_IWRD, MV_IWRD_WR: begin
                {bb, bs, sb, ss} = {3'd5, 4'd7, 3'd4, 4'd6};
                ext_pen_o = XP_WORD;
            end
            MV_BYT_IDRD, MV_IDRD_BYT: begin
                {bb, bs, sb, ss} = {3'd5, 4'd7, 3'd4, 4'd6};
                ext_pen_o = XP_N2;
            end
            MV_WR_IDRD, MV_IDRD_WR: begin
                {bb, bs, sb, ss} = {3'd5, 4'd8, 3'd4, 4'd7};
                ext_pen_o = XP_WORD;
            end
            MV_X_A_IND: {bb, bs, sb, ss} = {3'd1, 4'd4, 3'd1, 4'd5};
            // the external load pays one state more per access than the store
            MV_X_A_PTR16: begin
                {bb, bs, sb, ss} = {3'd1, 4'd3, 3'd1, 4'd3};
                ext_pen_o = XP_N2;
            end
            MV_X_IND_A: {bb, bs, sb, ss} = {3'd1, 4'd4, 3'd1, 4'd4};
            MV_X_PTR16_A: begin
                {bb, bs, sb, ss} = {3'd1, 4'd4, 3'd1, 4'd4};
                ext_pen_o = XP_N1;
            end
            default: {bb, bs, sb, ss} = {3'd1, 4'd1, 3'd1, 4'd1};
        endcase
    end

    // mode picks the escape-prefixed or plain encoding
    assign bytes_o = source_mode_i ? sb : bb;
    assign states_o = {4'h0, (source_mode_i ? ss : bs)};

endmodule : move_cost_table

// *** verilog/move_instruction_timing.sv ***
`timescale 1ns/1ns
`include "move_timing_cfg.svh"

module move_instruction_timing
    import move_timing_pkg::*;
#(
    parameter int WAIT_W = `WAIT_W
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire move_form_t form_i,
    input wire logic source_mode_i,
    input wire dir_loc_t dir_loc_a_i,
    input wire dir_loc_t dir_loc_b_i,
    input wire logic ext_access_i,
    input wire logic [WAIT_W-1:0] wait_states_i,
    input wire logic [15:0] imm16_i,
    input wire logic page_wr_i,
    input wire logic [7:0] page_data_i,
    input wire logic [15:0] data_pointer_16_i,
    output logic busy_o,
    output logic done_o,
    output logic [2:0] inst_bytes_o,
    output logic [`STATE_W-1:0] inst_states_o,
    output logic [31:0] dword_imm_o,
    output logic [7:0] ext_data_page_reg_o,
    output logic [23:0] ext_addr_o
);
    logic [2:0] base_bytes;
    logic [`STATE_W-1:0] base_states;
    logic [1:0] dir_ops;
    ext_pen_t ext_pen;
    logic [`STATE_W-1:0] dir_pen;
    logic [`STATE_W-1:0] ext_add;
    logic [`STATE_W-1:0] n_w;
    logic [`STATE_W-1:0] total_d;
    logic [`STATE_W-1:0] total_q;
    logic [`STATE_W-1:0] count_q;
    logic [2:0] bytes_q;
    logic [31:0] dword_q;
    logic [7:0] page_q;
    seq_state_t state_q;

    move_cost_table u_cost (
        .form_i(form_i),
        .source_mode_i(source_mode_i),
        .bytes_o(base_bytes),
        .states_o(base_states),
        .dir_ops_o(dir_ops),
        .ext_pen_o(ext_pen)
    );

    // penalty for one direct operand by location kind
    function automatic logic [`STATE_W-1:0] loc_pen(input dir_loc_t loc);
        case (loc)
            LOC_PORT: loc_pen = `PORT_EXTRA;
            LOC_PERIPH: loc_pen = `PERIPH_EXTRA;
            default: loc_pen = '0;
        endcase
    endfunction : loc_pen

    // each direct operand is charged on its own, except in the word and dword D8 forms, the second only for direct-to-direct
    always_comb begin
        dir_pen = '0;
        if (dir_ops != 2'h0) begin
            dir_pen = loc_pen(dir_loc_a_i);
        end
        if (dir_ops == 2'h2) begin
            dir_pen = dir_pen + loc_pen(dir_loc_b_i);
        end
    end

    assign n_w = `STATE_W'(wait_states_i);

    // wait-state penalty only when the access really leaves the chip
    always_comb begin
        ext_add = '0;
        if (ext_access_i) begin
            case (ext_pen)
                XP_N1: ext_add = n_w + `STATE_W'(1);
                XP_N2: ext_add = n_w + `STATE_W'(2);
                XP_WORD: ext_add = `STATE_W'((n_w + `STATE_W'(1)) << 1);
                XP_DWORD: ext_add = `STATE_W'((n_w + `STATE_W'(2)) << 2);
                default: ext_add = '0;
            endcase
        end
    end

    assign total_d = base_states + dir_pen + ext_add;

    // sequencer: counts the charged states, done pulses on the last one
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            count_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start_i) begin
                        count_q <= total_d - `STATE_W'(1);
                        state_q <= (total_d == `STATE_W'(1)) ? ST_DONE : ST_RUN;
                    end
                end
                ST_RUN: begin
                    count_q <= count_q - `STATE_W'(1);
                    if (count_q == `STATE_W'(1)) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    count_q <= '0;
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // latch lengths and immediate result at start; held until the next start
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            bytes_q <= '0;
            total_q <= '0;
            dword_q <= '0;
        end else if (start_i && state_q == ST_IDLE) begin
            bytes_q <= base_bytes;
            total_q <= total_d;
            if (form_i == MV_DR_IMM1) begin
                dword_q <= {16'hFFFF, imm16_i};
            end else begin
                dword_q <= {16'h0000, imm16_i};
            end
        end
    end

    // external page register; software-side writes come in through page_wr_i
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            page_q <= `XPAGE_RESET;
        end else if (page_wr_i) begin
            page_q <= page_data_i;
        end
    end

    assign busy_o = (state_q != ST_IDLE);
    assign done_o = (state_q == ST_DONE);
    assign inst_bytes_o = bytes_q;
    assign inst_states_o = total_q;
    assign dword_imm_o = dword_q;
    assign ext_data_page_reg_o = page_q;
    // upper address region comes from the page register
    assign ext_addr_o = {page_q, data_pointer_16_i};

endmodule : move_instruction_timing

// *** sim/move_instruction_timing_monitor.sv ***
`timescale 1ns/1ns
`include "move_timing_cfg.svh"

// watches timing outputs of the move sequencer
module move_timing_monitor
    import move_timing_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire move_form_t form_i,
    input wire logic source_mode_i,
    input wire dir_loc_t dir_loc_a_i,
    input wire dir_loc_t dir_loc_b_i,
    input wire logic [15:0] imm16_i,
    input wire logic [15:0] data_pointer_16_i,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic [2:0] inst_bytes_o,
    input wire logic [`STATE_W-1:0] inst_states_o,
    input wire logic [31:0] dword_imm_o,
    input wire logic [7:0] ext_data_page_reg_o,
    input wire logic [23:0] ext_addr_o
);
    default clocking mon_cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    logic take;
    logic [`STATE_W-1:0] span_q;

    // a request only counts while idle
    assign take = start_i && !busy_o;

    // busy-cycle count, so done can be tied to the reported total
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            span_q <= 8'h00;
        end else if (take) begin
            span_q <= 8'h01;
        end else if (busy_o) begin
            span_q <= span_q + 8'h01;
        end
    end

    property p_page_reset;
        disable iff (1'b0) !rst_n_i |=> ext_data_page_reg_o == `XPAGE_RESET;
    endproperty
    a_page_reset: assert property (p_page_reset) else $error("page not 01h after reset");
    property p_ext_addr;
        ext_addr_o == {ext_data_page_reg_o, data_pointer_16_i};
    endproperty
    a_ext_addr: assert property (p_ext_addr) else $error("extended address wrong");
    // totals must stand while busy, since a start then is refused
    property p_hold;
        busy_o |=> $stable(inst_states_o) && $stable(inst_bytes_o);
    endproperty
    a_hold: assert property (p_hold) else $error("totals changed while busy");
    property p_done_span;
        done_o |-> busy_o && span_q == inst_states_o ##1 !busy_o && !done_o;
    endproperty
    a_done_span: assert property (p_done_span) else $error("done not after total states");
    property p_data_pointer_16_imm;
        take && form_i == MV_PTR16_IMM16 |=> inst_bytes_o == 3'h3 && inst_states_o == 8'h02;
    endproperty
    a_data_pointer_16_imm: assert property (p_data_pointer_16_imm) else $error("pointer load count wrong");
    property p_dr_dr;
        take && form_i == MV_DR_DR |=>
            inst_states_o == ($past(source_mode_i) ? 8'h02 : 8'h03);
    endproperty
    a_dr_dr: assert property (p_dr_dr) else $error("dword move count wrong");
    property p_rm_rm;
        take && form_i == MV_BYT_BYT && source_mode_i |=> inst_bytes_o == 3'h2 && done_o;
    endproperty
    a_rm_rm: assert property (p_rm_rm) else $error("byte move count wrong");
    property p_dr_imm;
        take && (form_i == MV_DR_IMM0 || form_i == MV_DR_IMM1) |=>
            dword_imm_o == {{16{$past(form_i) == MV_DR_IMM1}}, $past(imm16_i)};
    endproperty
    a_dr_imm: assert property (p_dr_imm) else $error("dword immediate extension wrong");
    property p_dir_t1;
        take && form_i == MV_BNK_D8 && !source_mode_i && dir_loc_a_i == LOC_RAM &&
            dir_loc_b_i == LOC_RAM |=> done_o ##1 !busy_o;
    endproperty
    a_dir_t1: assert property (p_dir_t1) else $error("one-state move not done");

    c_source: cover property (take && source_mode_i);
    c_long: cover property (done_o && inst_states_o > 8'h08);
    c_two_dir: cover property (take && form_i == MV_D8_D8);
endmodule : move_timing_monitor

bind move_instruction_timing move_timing_monitor mon_u (.clock_i, .rst_n_i, .start_i, .form_i,
    .source_mode_i, .dir_loc_a_i, .dir_loc_b_i, .imm16_i, .data_pointer_16_i, .busy_o, .done_o,
    .inst_bytes_o, .inst_states_o, .dword_imm_o, .ext_data_page_reg_o, .ext_addr_o);

// *** sim/move_instruction_timing_test.sv ***
`timescale 1ns/1ns
`include "move_timing_cfg.svh"

module move_instruction_timing_test;
    import move_timing_pkg::*;
    logic clock_i, rst_n_i, start_i, source_mode_i, ext_access_i, page_wr_i;
    move_form_t form_i;
    dir_loc_t dir_loc_a_i, dir_loc_b_i;
    logic [3:0] wait_states_i;
    logic [15:0] imm16_i, data_pointer_16_i;
    logic [7:0] page_data_i, ext_data_page_reg_o;
    logic busy_o, done_o;
    logic [2:0] inst_bytes_o;
    logic [`STATE_W-1:0] inst_states_o;
    logic [31:0] dword_imm_o;
    logic [23:0] ext_addr_o;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;

    move_instruction_timing dut_u (.clock_i, .rst_n_i, .start_i, .form_i, .source_mode_i,
        .dir_loc_a_i, .dir_loc_b_i, .ext_access_i, .wait_states_i, .imm16_i, .page_wr_i,
        .page_data_i, .data_pointer_16_i, .busy_o, .done_o, .inst_bytes_o, .inst_states_o,
        .dword_imm_o, .ext_data_page_reg_o, .ext_addr_o);

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    task automatic close_out();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    // hang guard: the whole run needs far fewer cycles
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            close_out();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    // one move: start, then time done against the expected total
    task automatic run(input move_form_t f, input logic src, input dir_loc_t la,
                       input dir_loc_t lb, input logic ext, input logic [3:0] n,
                       input logic [31:0] eb, input logic [31:0] es);
        int cnt;
        @(negedge clock_i);
        form_i = f;
        source_mode_i = src;
        dir_loc_a_i = la;
        dir_loc_b_i = lb;
        ext_access_i = ext;
        wait_states_i = n;
        start_i = 1'b1;
        @(negedge clock_i);
        start_i = 1'b0;
        cnt = 1;
        check("busy", busy_o, 32'h1);
        check("bytes", inst_bytes_o, eb);
        check("states", inst_states_o, es);
        while (done_o !== 1'b1 && cnt < 300) begin
            @(negedge clock_i);
            cnt++;
        end
        check("done cycle", cnt, es);
        @(negedge clock_i);
        check("idle", busy_o, 32'h0);
    endtask : run

    // same form in binary, then source mode, all on-chip
    task automatic both(input move_form_t f, input logic [31:0] bb, input logic [31:0] bs,
                        input logic [31:0] sb, input logic [31:0] ss);
        run(f, 1'b0, LOC_RAM, LOC_RAM, 1'b0, 4'h0, bb, bs);
        run(f, 1'b1, LOC_RAM, LOC_RAM, 1'b0, 4'h0, sb, ss);
    endtask : both

    task automatic t_page();
        check("page", ext_data_page_reg_o, 32'h01);
        check("ext addr", ext_addr_o, 32'h01A55A);
        @(negedge clock_i);
        page_data_i = 8'h3C;
        page_wr_i = 1'b1;
        @(negedge clock_i);
        page_wr_i = 1'b0;
        check("ext addr", ext_addr_o, 32'h3CA55A);
        // a second reset must bring the page back
        rst_n_i = 1'b0;
        @(negedge clock_i);
        rst_n_i = 1'b1;
        check("page", ext_data_page_reg_o, 32'h01);
        $display("test page done");
    endtask : t_page

    task automatic t_modes();
        both(MV_PTR16_IMM16, 3, 2, 3, 2);
        both(MV_D8_IMM, 3, 3, 3, 3);
        both(MV_DR_DR, 3, 3, 2, 2);
        both(MV_DR_IMM1, 5, 5, 4, 4);
        both(MV_DR_D16, 5, 6, 4, 5);
        both(MV_BYT_IDR, 4, 4, 3, 3);
        both(MV_IDR_WR, 4, 6, 3, 5);
        both(MV_BYT_IWRD, 5, 6, 4, 5);
        both(MV_D16_DR, 5, 7, 4, 6);
        both(MV_BNK_D8, 2, 1, 3, 2);
        both(MV_IND_A, 1, 3, 2, 4);
        both(MV_BYT_BYT, 3, 2, 2, 1);
        $display("test modes done");
    endtask : t_modes

    task automatic t_direct();
        run(MV_D8_D8, 1'b0, LOC_PORT, LOC_PERIPH, 1'b0, 4'h0, 3, 6);
        run(MV_D8_D8, 1'b1, LOC_PERIPH, LOC_PERIPH, 1'b0, 4'h0, 3, 7);
        run(MV_D8_D8, 1'b0, LOC_PORT, LOC_RAM, 1'b0, 4'h0, 3, 4);
        run(MV_D8_IMM, 1'b0, LOC_PORT, LOC_PORT, 1'b0, 4'h0, 3, 4);
        run(MV_D8_IMM, 1'b1, LOC_PERIPH, LOC_PERIPH, 1'b0, 4'h0, 3, 5);
        run(MV_BNK_D8, 1'b1, LOC_PORT, LOC_PORT, 1'b0, 4'h0, 3, 3);
        run(MV_A_D8, 1'b0, LOC_PERIPH, LOC_PORT, 1'b0, 4'h0, 2, 3);
        run(MV_D8_BYT, 1'b1, LOC_PORT, LOC_PERIPH, 1'b0, 4'h0, 3, 4);
        $display("test direct done");
    endtask : t_direct

    // wait count 3 unless noted; zero checks the plain offsets
    task automatic t_external();
        run(MV_BYT_IDR, 1'b0, LOC_RAM, LOC_RAM, 1'b1, 4'h3, 4, 9);
        run(MV_IDR_WR, 1'b1, LOC_RAM, LOC_RAM, 1'b1, 4'h3, 3, 13);
        run(MV_DR_D16, 1'b1, LOC_RAM, LOC_RAM, 1'b1, 4'h3, 4, 25);
        run(MV_BYT_IWRD, 1'b0, LOC_RAM, LOC_RAM, 1'b1, 4'h0, 5, 8);
        run(MV_D16_DR, 1'b0, LOC_RAM, LOC_RAM, 1'b1, 4'h0, 5, 15);
        run(MV_X_A_PTR16, 1'b0, LOC_RAM, LOC_RAM, 1'b1, 4'h3, 1, 8);
        run(MV_X_PTR16_A, 1'b1, LOC_RAM, LOC_RAM, 1'b1, 4'h3, 1, 8);
        run(MV_X_A_IND, 1'b1, LOC_RAM, LOC_RAM, 1'b1, 4'h3, 1, 5);
        $display("test external done");
    endtask : t_external

    task automatic t_imm();
        imm16_i = 16'h8001;
        run(MV_DR_IMM0, 1'b0, LOC_RAM, LOC_RAM, 1'b0, 4'h0, 5, 5);
        check("dword imm", dword_imm_o, 32'h00008001);
        run(MV_DR_IMM1, 1'b1, LOC_RAM, LOC_RAM, 1'b0, 4'h0, 4, 4);
        check("dword imm", dword_imm_o, 32'hFFFF8001);
        $display("test immediate done");
    endtask : t_imm

    // a start while busy must not disturb the running count
    task automatic t_refuse();
        int cnt;
        @(negedge clock_i);
        form_i = MV_DR_D16;
        source_mode_i = 1'b0;
        ext_access_i = 1'b1;
        wait_states_i = 4'h3;
        start_i = 1'b1;
        @(negedge clock_i);
        form_i = MV_BYT_BYT;
        @(negedge clock_i);
        start_i = 1'b0;
        cnt = 2;
        while (done_o !== 1'b1 && cnt < 300) begin
            @(negedge clock_i);
            cnt++;
        end
        check("refused states", inst_states_o, 32'd26);
        check("refused done", cnt, 32'd26);
        @(negedge clock_i);
        check("refused idle", busy_o, 32'h0);
        $display("test refuse done");
    endtask : t_refuse

    initial begin
        rst_n_i = 1'b0;
        start_i = 1'b0;
        form_i = MV_A_BNK;
        source_mode_i = 1'b0;
        dir_loc_a_i = LOC_RAM;
        dir_loc_b_i = LOC_RAM;
        ext_access_i = 1'b0;
        wait_states_i = 4'h0;
        imm16_i = 16'h0000;
        page_wr_i = 1'b0;
        page_data_i = 8'h00;
        data_pointer_16_i = 16'hA55A;
        repeat (6) @(negedge clock_i);
        rst_n_i = 1'b1;
        t_page();
        t_modes();
        t_direct();
        t_external();
        t_imm();
        t_refuse();
        close_out();
    end
endmodule : move_instruction_timing_test
